// File: shared/timer_b_defs.svh
// Behaviour
// - While counting, a read of the counter returns the live count without disturbing it, except in the reload cycle.
// - In timer or event counter mode, a read in the reload cycle returns all ones instead of the reloaded count.
// - A value written while counting is halted is what a read returns until counting starts.
// - In a measurement mode, changing the measured-quantity select bit after counting starts sets the interrupt request flag.
// - In a measurement mode, the first qualifying edge after start transfers an undefined count to the reload register, to be discarded by software.
// - The first qualifying edge after start in a measurement mode raises no interrupt request; later edges capture valid measurements.
`ifndef TIMER_B_DEFS_SVH
`define TIMER_B_DEFS_SVH
`define TB_WIDTH 16
`define TB_COUNT_RESET 16'h0000
`define TB_RELOAD_RESET 16'h0000
`define TB_READ_RESET 16'h0000
`define TB_READ_ON_RELOAD 16'hFFFF
`endif

// File: shared/timer_b_pkg.sv
package timer_b_pkg;
	typedef enum logic [1:0] {
		MODE_TIMER = 2'b00,
		MODE_EVENT = 2'b01,
		MODE_MEASURE = 2'b10,
		MODE_SPARE = 2'b11
	} tb_mode_t;
	typedef enum logic [0:0] {
		MEAS_PERIOD = 1'b0,
		MEAS_WIDTH = 1'b1
	} tb_meas_t;
endpackage

// File: core/timer_b_edge.sv
`timescale 1ns/10ps
`default_nettype none
module timer_b_edge
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// pin and selection
	input wire logic pin_i,
	input wire logic width_sel_i,
	// detected edges
	output logic qual_edge_o,
	output logic any_edge_o
);
	logic pin_reg;
	logic rise;
	logic fall;

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			pin_reg <= 1'b0;
		else
			pin_reg <= pin_i;
	end

	assign rise = pin_i && !pin_reg;
	assign fall = !pin_i && pin_reg;
	// period: falling edges; width: both edges
	assign qual_edge_o = width_sel_i ? (rise || fall) : fall;
	assign any_edge_o = rise || fall;
endmodule // timer_b_edge
`default_nettype wire

// File: core/timer_b_channel.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer_b_defs.svh"
module timer_b_channel
#(
	parameter int WIDTH = `TB_WIDTH
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// control
	input wire timer_b_pkg::tb_mode_t mode_i,
	input wire timer_b_pkg::tb_meas_t meas_sel_i,
	input wire logic start_i,
	// count sources
	input wire logic count_pulse_i,
	input wire logic event_pin_i,
	// counter access
	input wire logic wr_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic rd_i,
	output logic [WIDTH-1:0] rd_data_o,
	output logic [WIDTH-1:0] reload_o,
	// interrupt request
	input wire logic irq_clear_i,
	output logic irq_o
);
	import timer_b_pkg::*;

	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] reload_reg;
	logic [WIDTH-1:0] rd_reg;
	logic irq_reg;
	logic first_reg;
	logic meas_sel_reg;
	logic qual_edge;
	logic any_edge;
	logic measuring;
	logic tick;
	logic underflow;
	logic capture;
	logic sel_change;

	timer_b_edge edge_det
	(
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.pin_i(event_pin_i),
		.width_sel_i(meas_sel_i == MEAS_WIDTH),
		.qual_edge_o(qual_edge),
		.any_edge_o(any_edge)
	);

	// ----------------------------------------
	// count sources
	// ----------------------------------------
	assign measuring = (mode_i == MODE_MEASURE);
	assign tick = (mode_i == MODE_EVENT) ? (any_edge && !event_pin_i) : count_pulse_i;
	assign underflow = start_i && !measuring && tick && (count_reg == '0);
	assign capture = start_i && measuring && qual_edge;
	assign sel_change = start_i && measuring && (meas_sel_reg != meas_sel_i);

	// ----------------------------------------
	// counter
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			count_reg <= `TB_COUNT_RESET;
		else if (!start_i && wr_i)
			count_reg <= wr_data_i;
		else if (underflow)
			count_reg <= reload_reg;
		else if (start_i && !measuring && tick)
			count_reg <= count_reg - WIDTH'(1);
		else if (capture)
			count_reg <= '0;
		else if (start_i && measuring && count_pulse_i)
			count_reg <= count_reg + WIDTH'(1);
	end

	// ----------------------------------------
	// reload register
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			reload_reg <= `TB_RELOAD_RESET;
		else if (capture)
			reload_reg <= count_reg;
		else if (!measuring && wr_i)
			reload_reg <= wr_data_i;
	end

	// ----------------------------------------
	// first edge tracking
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			first_reg <= 1'b1;
		else if (!start_i)
			first_reg <= 1'b1;
		else if (capture)
			first_reg <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			meas_sel_reg <= 1'b0;
		else
			meas_sel_reg <= meas_sel_i;
	end

	// ----------------------------------------
	// interrupt request, set beats clear
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			irq_reg <= 1'b0;
		else if (underflow || sel_change || (capture && !first_reg))
			irq_reg <= 1'b1;
		else if (irq_clear_i)
			irq_reg <= 1'b0;
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			rd_reg <= `TB_READ_RESET;
		else if (rd_i && underflow)
			rd_reg <= `TB_READ_ON_RELOAD;
		else if (rd_i)
			rd_reg <= count_reg;
	end

	assign rd_data_o = rd_reg;
	assign reload_o = reload_reg;
	assign irq_o = irq_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	reload_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		rd_i && underflow |=> rd_data_o == `TB_READ_ON_RELOAD)
		else $error("read at reload not all ones");
	live_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		rd_i && !underflow |=> rd_data_o == $past(count_reg))
		else $error("read not live count");
	halted_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!start_i && wr_i ##1 (!start_i && !wr_i && rd_i) |=> rd_data_o == $past(wr_data_i, 2))
		else $error("halted write not read back");
	sel_change_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		sel_change |=> irq_o)
		else $error("select change no irq");
	capture_load_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		capture |=> reload_o == $past(count_reg))
		else $error("capture not loaded");
	first_edge_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		capture && first_reg && !irq_o && !underflow && !sel_change |=> !irq_o)
		else $error("first edge raised irq");
	underflow_irq_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		underflow && !wr_i |=> irq_o && count_reg == $past(reload_reg))
		else $error("underflow not reloaded");
	decrement_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		start_i && !measuring && tick && count_reg != '0 && !wr_i
		|=> count_reg == $past(count_reg) - WIDTH'(1))
		else $error("no decrement");

	// ----------------------------------------
	// checks, counter and reload
	// ----------------------------------------
	halted_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!start_i && !wr_i |=> $stable(count_reg))
		else $error("halted count moved");
	halted_load_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!start_i && wr_i |=> count_reg == $past(wr_data_i))
		else $error("halted write not in counter");
	running_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		start_i && wr_i && !measuring && !tick |=> $stable(count_reg))
		else $error("running write disturbed count");
	reload_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		start_i && wr_i && !measuring |=> reload_o == $past(wr_data_i))
		else $error("running write not in reload");
	event_idle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		mode_i == MODE_EVENT && start_i && !(any_edge && !event_pin_i) |=> $stable(count_reg))
		else $error("event count moved without falling edge");
	measure_count_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		start_i && measuring && count_pulse_i && !qual_edge
		|=> count_reg == $past(count_reg) + WIDTH'(1))
		else $error("measurement count not incremented");
	capture_restart_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		capture |=> count_reg == '0)
		else $error("count not restarted at capture");
	measure_reload_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		measuring && !capture |=> $stable(reload_o))
		else $error("reload moved without capture");

	// ----------------------------------------
	// checks, request and read
	// ----------------------------------------
	first_arm_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!start_i |=> first_reg)
		else $error("first edge not armed");
	first_done_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		capture |=> !first_reg)
		else $error("first edge not consumed");
	later_edge_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		capture && !first_reg |=> irq_o)
		else $error("later edge no irq");
	irq_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		irq_o && !irq_clear_i |=> irq_o)
		else $error("irq dropped without clear");
	irq_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		irq_clear_i && !underflow && !sel_change && !capture |=> !irq_o)
		else $error("irq not cleared");
	read_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!rd_i |=> $stable(rd_data_o))
		else $error("read data moved without read");
endmodule // timer_b_channel
`default_nettype wire

// File: test/pulse_src.sv
`timescale 1ns/10ps
`default_nettype none
module pulse_src
(
	// clock and control
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [7:0] half_i,
	// event pin
	output logic pin_o
);
	int n = 0;
	initial pin_o = 1'b0;
	// square wave while enabled, low otherwise
	always @(posedge clk_i)
	begin
		n <= (go_i && n + 1 < half_i) ? n + 1 : 0;
		if (!go_i)
			pin_o <= #1 1'b0;
		else if (n + 1 >= half_i)
			pin_o <= #1 ~pin_o;
	end
endmodule // pulse_src
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import timer_b_pkg::*;
	logic clk_i = 0, reset_n_i = 0, start_i = 0, count_pulse_i = 0;
	logic wr_i = 0, rd_i = 0, irq_clear_i = 0, go = 0;
	tb_mode_t mode_i = MODE_TIMER;
	tb_meas_t meas_sel_i = MEAS_PERIOD;
	logic [15:0] wr_data_i = 16'h0000, w, v;
	logic [7:0] h = 8'h04;
	logic [31:0] lf = 32'hE2A12FD0;
	wire logic event_pin_i, irq_o;
	wire logic [15:0] rd_data_o, reload_o;
	int fail_count = 0, n_compared = 0;
	timer_b_channel i_dut(.clk_i(clk_i), .reset_n_i(reset_n_i), .mode_i(mode_i),
		.meas_sel_i(meas_sel_i), .start_i(start_i), .count_pulse_i(count_pulse_i),
		.event_pin_i(event_pin_i), .wr_i(wr_i), .wr_data_i(wr_data_i), .rd_i(rd_i),
		.rd_data_o(rd_data_o), .reload_o(reload_o), .irq_clear_i(irq_clear_i), .irq_o(irq_o));
	pulse_src i_src(.clk_i(clk_i), .go_i(go), .half_i(h), .pin_o(event_pin_i));
	initial forever #5 clk_i = ~clk_i;
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic near(input logic [15:0] got, input logic [15:0] want);
		return (got + 16'h0002 >= want) && (got <= want + 16'h0002);
	endfunction
	task step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task chk(input string s, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", s, e, g);
			fail_count++;
		end
	endtask
	task rd();
		rd_i = 1;
		step(1);
		rd_i = 0;
		v = rd_data_o;
	endtask
	task results();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		#100000;
		fail_count++;
		results();
	end
	initial
	begin
		step(4);
		chk("reset read", 16'h0000, rd_data_o);
		chk("reset reload", 16'h0000, reload_o);
		chk("reset irq", 16'h0000, {15'h0000, irq_o});
		reset_n_i = 1;
		repeat (4)
		begin
			lf = nx(lf);
			w = {12'h000, lf[3:0]} + 16'h0002;
			start_i = 0;
			irq_clear_i = 1;
			wr_data_i = w;
			wr_i = 1;
			step(1);
			wr_i = 0;
			irq_clear_i = 0;
			rd();
			chk("halted read", w, v);
			start_i = 1;
			step(1);
			count_pulse_i = 1;
			step(w);
			count_pulse_i = 0;
			rd();
			chk("live count", 16'h0000, v);
			chk("irq before underflow", 16'h0000, {15'h0000, irq_o});
			step(1);
			count_pulse_i = 1;
			rd();
			count_pulse_i = 0;
			chk("reload read", 16'hFFFF, v);
			chk("underflow irq", 16'h0001, {15'h0000, irq_o});
			step(1);
			rd();
			chk("reloaded count", w, v);
		end
		start_i = 0;
		mode_i = MODE_MEASURE;
		irq_clear_i = 1;
		step(1);
		irq_clear_i = 0;
		start_i = 1;
		step(2);
		chk("irq before select change", 16'h0000, {15'h0000, irq_o});
		meas_sel_i = MEAS_WIDTH;
		step(2);
		chk("select change irq", 16'h0001, {15'h0000, irq_o});
		start_i = 0;
		step(1);
		meas_sel_i = MEAS_PERIOD;
		irq_clear_i = 1;
		step(1);
		irq_clear_i = 0;
		lf = nx(lf);
		h = {5'h00, lf[2:0]} + 8'h04;
		count_pulse_i = 1;
		start_i = 1;
		go = 1;
		@(negedge event_pin_i);
		step(4);
		chk("first edge irq", 16'h0000, {15'h0000, irq_o});
		@(negedge event_pin_i);
		step(4);
		chk("second edge irq", 16'h0001, {15'h0000, irq_o});
		chk("period", 16'h0001, {15'h0000, near(reload_o, {7'h00, h, 1'b0})});
		start_i = 0;
		go = 0;
		meas_sel_i = MEAS_WIDTH;
		irq_clear_i = 1;
		step(2);
		irq_clear_i = 0;
		start_i = 1;
		go = 1;
		@(posedge event_pin_i);
		step(2);
		chk("width first irq", 16'h0000, {15'h0000, irq_o});
		@(negedge event_pin_i);
		step(2);
		chk("width irq", 16'h0001, {15'h0000, irq_o});
		chk("width", 16'h0001, {15'h0000, near(reload_o, {8'h00, h})});
		start_i = 0;
		go = 0;
		mode_i = MODE_EVENT;
		irq_clear_i = 1;
		lf = nx(lf);
		w = {14'h0000, lf[1:0]} + 16'h0002;
		wr_data_i = w;
		wr_i = 1;
		step(1);
		wr_i = 0;
		irq_clear_i = 0;
		step(1);
		start_i = 1;
		go = 1;
		wr_data_i = w + 16'h0003;
		wr_i = 1;
		step(1);
		wr_i = 0;
		rd();
		chk("running write count", w, v);
		repeat (w) @(negedge event_pin_i);
		step(1);
		rd();
		chk("event count", 16'h0000, v);
		chk("irq before event underflow", 16'h0000, {15'h0000, irq_o});
		@(negedge event_pin_i);
		rd();
		chk("event reload read", 16'hFFFF, v);
		chk("event underflow irq", 16'h0001, {15'h0000, irq_o});
		step(1);
		rd();
		chk("event reloaded", w + 16'h0003, v);
		results();
	end
endmodule // tb_top
`default_nettype wire
